//--- rtl/mmu_translation_user_map.sv
/*
  user-segment address translation with a 32-entry fully associative
  translation buffer, operating-mode tracking and physical region decode.
  assumes the pipeline on ref_clk presents one lookup per cycle and
  takes the answer combinationally in that same cycle; software fills
  entries over classic Wishbone.
*/
// Our own choices: the address map and the Wishbone interface to the registers.
// How it works
// - physical address is 32 bits, 4 Gbytes
// - 0x1f000000-0x1fffffff decodes as rom
// - 0x18000000-0x18ffffff aliases the rom
// - above 0x1fffffff mirrors the low 512 Mbytes
// - expansion io: 16-bit at 0x17, 8-bit 0x16
// - expansion memory: 16-bit 0x15, 8-bit 0x14
// - 0x0b000000 block selects hardware registers
// - 0x0a000000 block selects display buffer
// - hit needs vpn match and global or tag
// - no hit raises translation miss
// - frame number joined with untranslated offset
// - five page sizes, 1K to 256K
// - 32-bit vpn spans 22 down to 14 bits
// - 64-bit vpn spans 30 down to 22 bits
// - exceptions enter kernel, return restores mode
// - user mode: privilege 10, both levels 0
// - wide bit picks 32 or 64-bit segment
// - user segments end 0x7fffffff, 0xffffffffff
// - 32-bit user with msb set: address error
// - 64-bit user, bits 63:40 nonzero: error
// - 32-bit misses use ordinary miss vector
// - 64-bit misses use extended miss vector
// - user segment mapped, entry sets cacheability
// - 32-bit addresses sign-extend bit 31
// - 32 entries of page pairs, parallel compare
// - current 8-bit tag in entry-high register
// - multiple hit sets shutdown until reset
`timescale 1ns/1ns
`include "mmu_params.svh"

module mmu_translation_user_map #(
  parameter int ENTRIES = 32,
  parameter int TAG_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pipeline side
  input wire logic lookup_req,
  input wire logic [63:0] lookup_vaddr,
  input wire logic exception_in,
  input wire logic exception_return,
  output logic [31:0] lookup_paddr,
  output logic lookup_hit,
  output logic lookup_cacheable,
  output logic translation_miss,
  output logic extended_translation_miss,
  output logic address_error,
  output logic unmapped,
  output logic user_mode,
  output logic kernel_mode,
  output mmu_pkg::region_type region,
  output logic translation_shutdown_bit
);

  localparam int IDX_W = $clog2(ENTRIES);

  ////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // offset bits of a page: 10, 12, 14, 16 or 18
  function automatic logic [31:0] off_mask(
    input mmu_pkg::page_size_type k
  );
    case (k)
      3'h1: off_mask = 32'h0000_0fff;
      3'h2: off_mask = 32'h0000_3fff;
      3'h3: off_mask = 32'h0000_ffff;
      3'h4: off_mask = 32'h0003_ffff;
      default: off_mask = 32'h0000_03ff;
    endcase
  endfunction

  // vpn of a pair is address bits 39:11; larger pages drop low bits
  function automatic logic [28:0] vpn_mask(
    input mmu_pkg::page_size_type k
  );
    case (k)
      3'h1: vpn_mask = 29'h0000_0003;
      3'h2: vpn_mask = 29'h0000_000f;
      3'h3: vpn_mask = 29'h0000_003f;
      3'h4: vpn_mask = 29'h0000_00ff;
      default: vpn_mask = 29'h0000_0000;
    endcase
  endfunction

  // the bit just above the offset picks the odd page of the pair
  function automatic logic odd_page(
    input logic [63:0] va,
    input mmu_pkg::page_size_type k
  );
    case (k)
      3'h1: odd_page = va[12];
      3'h2: odd_page = va[14];
      3'h3: odd_page = va[16];
      3'h4: odd_page = va[18];
      default: odd_page = va[10];
    endcase
  endfunction

  function automatic mmu_pkg::region_type decode(
    input logic [31:0] pa
  );
    logic [4:0] blk;
    blk = pa[28:24];
    if (blk == `MMU_RGN_ROM || blk == `MMU_RGN_ROM_ALIAS) begin
      decode = mmu_pkg::rgn_rom;
    end else if (blk == `MMU_RGN_IO16) begin
      decode = mmu_pkg::rgn_io16;
    end else if (blk == `MMU_RGN_IO8) begin
      decode = mmu_pkg::rgn_io8;
    end else if (blk == `MMU_RGN_MEM16) begin
      decode = mmu_pkg::rgn_mem16;
    end else if (blk == `MMU_RGN_MEM8) begin
      decode = mmu_pkg::rgn_mem8;
    end else if (blk == `MMU_RGN_HWREG) begin
      decode = mmu_pkg::rgn_hwreg;
    end else if (blk == `MMU_RGN_DISP) begin
      decode = mmu_pkg::rgn_disp;
    end else if (blk <= `MMU_RGN_DRAM_TOP) begin
      decode = mmu_pkg::rgn_dram;
    end else begin
      decode = mmu_pkg::rgn_none;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] mode;
  logic [TAG_W-1:0] entry_high_control;
  logic [28:0] vpn_stage;
  logic [23:0] lo0_stage;
  logic [23:0] lo1_stage;
  mmu_pkg::page_size_type size_stage;
  logic [IDX_W-1:0] index_stage;
  logic last_miss;
  logic last_aerr;

  // entry storage
  logic ent_valid [ENTRIES];
  logic [28:0] ent_vpn [ENTRIES];
  logic [TAG_W-1:0] ent_tag [ENTRIES];
  logic ent_global [ENTRIES];
  mmu_pkg::page_size_type ent_size [ENTRIES];
  logic [23:0] ent_lo0 [ENTRIES];
  logic [23:0] ent_lo1 [ENTRIES];

  logic access;
  logic wr;
  logic [31:0] wdata;
  logic mmu_exception;
  logic take_exception;

  assign access = cyc_i && stb_i && !ack_o;
  // a write lands at the edge where the master sees ack high
  assign wr = cyc_i && stb_i && we_i && ack_o;

  ////////////////////////////////////////////////////////////////////
  // lookup, all combinational so the pipeline sees it this cycle

  logic [63:0] va;
  logic wide;
  logic in_useg;
  logic [ENTRIES-1:0] hits;
  logic multi;
  logic any_hit;
  logic [31:0] pa;
  logic cache_sel;

  assign wide = mode[`MMU_UX_BIT];
  assign user_mode = mode[`MMU_PRIV_LSB +: 2] == `MMU_PRIV_USER &&
                     !mode[`MMU_ERL_BIT] &&
                     !mode[`MMU_EXL_BIT];
  assign kernel_mode = mode[`MMU_ERL_BIT] || mode[`MMU_EXL_BIT] ||
                       mode[`MMU_PRIV_LSB +: 2] == 2'h0;

  always_comb begin
    va = wide ? lookup_vaddr :
      {{32{lookup_vaddr[31]}}, lookup_vaddr[31:0]};
  end

  assign in_useg = wide ? (va[63:40] == 24'h00_0000) : !va[31];

  always_comb begin
    hits = '0;
    for (int i = 0; i < ENTRIES; i++) begin
      hits[i] = ent_valid[i] &&
        (((ent_vpn[i] ^ va[39:11]) & ~vpn_mask(ent_size[i])) ==
         29'h0) &&
        (ent_global[i] || ent_tag[i] == entry_high_control);
    end
  end

  assign multi = |(hits & (hits - 1'b1));
  assign any_hit = |hits && !translation_shutdown_bit;

  always_comb begin
    logic [23:0] lo;
    logic [31:0] om;
    lo = '0;
    om = 32'h0000_03ff;
    for (int i = 0; i < ENTRIES; i++) begin
      if (hits[i]) begin
        lo = odd_page(va, ent_size[i]) ? ent_lo1[i] : ent_lo0[i];
        om = off_mask(ent_size[i]);
      end
    end
    pa = ({lo[`MMU_PFN_W-1:0], 10'h000} & ~om) | (va[31:0] & om);
    cache_sel = lo[`MMU_C_BIT];
  end

  always_comb begin
    lookup_paddr = 32'h0000_0000;
    lookup_hit = 1'b0;
    lookup_cacheable = 1'b0;
    translation_miss = 1'b0;
    extended_translation_miss = 1'b0;
    address_error = 1'b0;
    unmapped = 1'b0;
    region = mmu_pkg::rgn_none;
    if (lookup_req) begin
      if (user_mode && !in_useg) begin
        address_error = 1'b1;
      end else if (!in_useg) begin
        // other segments are handled outside this block
        unmapped = 1'b1;
        lookup_paddr = va[31:0];
        region = decode(va[31:0]);
      end else if (any_hit) begin
        lookup_hit = 1'b1;
        lookup_paddr = pa;
        lookup_cacheable = cache_sel;
        region = decode(pa);
      end else if (wide) begin
        extended_translation_miss = 1'b1;
      end else begin
        translation_miss = 1'b1;
      end
    end
  end

  assign mmu_exception = address_error || translation_miss ||
                         extended_translation_miss;
  assign take_exception = mmu_exception || exception_in;

  ////////////////////////////////////////////////////////////////////
  // mode: exception entry wins over a bus write in the same cycle

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mode <= `MMU_MODE_RESET;
    end else begin
      if (wr && adr_i == `MMU_MODE_OFS) begin
        mode <= merge(mode, dat_i, sel_i) & 32'h0000_003e;
      end
      if (take_exception) begin
        mode[`MMU_EXL_BIT] <= 1'b1;
      end else if (exception_return) begin
        // the error level is left first, as it is the outer one
        if (mode[`MMU_ERL_BIT]) begin
          mode[`MMU_ERL_BIT] <= 1'b0;
        end else begin
          mode[`MMU_EXL_BIT] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      translation_shutdown_bit <= 1'b0;
    end else if (lookup_req && in_useg && multi) begin
      translation_shutdown_bit <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      last_miss <= 1'b0;
      last_aerr <= 1'b0;
    end else if (lookup_req) begin
      last_miss <= translation_miss || extended_translation_miss;
      last_aerr <= address_error;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // staging registers for entry writes

  assign wdata = dat_i;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      entry_high_control <= '0;
      vpn_stage <= 29'h0;
      lo0_stage <= 24'h00_0000;
      lo1_stage <= 24'h00_0000;
      size_stage <= 3'h0;
      index_stage <= '0;
    end else if (wr) begin
      case (adr_i)
        `MMU_TAG_OFS: begin
          entry_high_control <= TAG_W'(merge(
            32'(entry_high_control), wdata, sel_i));
        end
        `MMU_VPN_OFS: begin
          vpn_stage <= 29'(merge(32'(vpn_stage), wdata, sel_i));
        end
        `MMU_LO0_OFS: begin
          lo0_stage <= 24'(merge(32'(lo0_stage), wdata, sel_i));
        end
        `MMU_LO1_OFS: begin
          lo1_stage <= 24'(merge(32'(lo1_stage), wdata, sel_i));
        end
        `MMU_SIZE_OFS: begin
          if (sel_i[0]) begin
            size_stage <= wdata[2:0];
          end
        end
        `MMU_INDEX_OFS: begin
          if (sel_i[0]) begin
            index_stage <= wdata[IDX_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // a command write copies the staged entry into the chosen slot
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        ent_valid[i] <= 1'b0;
      end
    end else if (wr && adr_i == `MMU_CMD_OFS && sel_i[0] &&
                 dat_i[0]) begin
      ent_valid[index_stage] <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (wr && adr_i == `MMU_CMD_OFS && sel_i[0] && dat_i[0]) begin
      ent_vpn[index_stage] <= vpn_stage;
      ent_tag[index_stage] <= entry_high_control;
      // an entry is global only if both pages say so
      ent_global[index_stage] <= lo0_stage[`MMU_G_BIT] &&
                                 lo1_stage[`MMU_G_BIT];
      ent_size[index_stage] <= size_stage;
      ent_lo0[index_stage] <= lo0_stage;
      ent_lo1[index_stage] <= lo1_stage;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // wishbone answer: one wait state, unmapped reads give zero

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= access;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      dat_o <= 32'h0000_0000;
    end else if (access && !we_i) begin
      case (adr_i)
        `MMU_MODE_OFS: dat_o <= mode;
        `MMU_TAG_OFS: dat_o <= 32'(entry_high_control);
        `MMU_VPN_OFS: dat_o <= 32'(vpn_stage);
        `MMU_LO0_OFS: dat_o <= 32'(lo0_stage);
        `MMU_LO1_OFS: dat_o <= 32'(lo1_stage);
        `MMU_SIZE_OFS: dat_o <= 32'(size_stage);
        `MMU_INDEX_OFS: dat_o <= 32'(index_stage);
        `MMU_STATUS_OFS: begin
          dat_o <= {29'h0, last_aerr, last_miss,
                    translation_shutdown_bit};
        end
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule // mmu_translation_user_map

//--- rtl/mmu_params.svh
/*
  offsets, field positions, reset values and physical region codes
  of the user-segment translation block.
  assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
`ifndef MMU_PARAMS_SVH
`define MMU_PARAMS_SVH

// register byte offsets
`define MMU_MODE_OFS 8'h00
`define MMU_TAG_OFS 8'h04
`define MMU_VPN_OFS 8'h08
`define MMU_LO0_OFS 8'h0c
`define MMU_LO1_OFS 8'h10
`define MMU_SIZE_OFS 8'h14
`define MMU_INDEX_OFS 8'h18
`define MMU_CMD_OFS 8'h1c
`define MMU_STATUS_OFS 8'h20

// mode register fields
`define MMU_EXL_BIT 1
`define MMU_ERL_BIT 2
`define MMU_PRIV_LSB 3
`define MMU_UX_BIT 5
`define MMU_MODE_RESET 32'h0000_0004
`define MMU_PRIV_USER 2'h2

// entry low fields
`define MMU_PFN_W 22
`define MMU_C_BIT 22
`define MMU_G_BIT 23

// status fields
`define MMU_TS_BIT 0
`define MMU_MISS_BIT 1
`define MMU_AERR_BIT 2

// physical region codes, taken from address bits 28:24
`define MMU_RGN_ROM 5'h1f
`define MMU_RGN_ROM_ALIAS 5'h18
`define MMU_RGN_IO16 5'h17
`define MMU_RGN_IO8 5'h16
`define MMU_RGN_MEM16 5'h15
`define MMU_RGN_MEM8 5'h14
`define MMU_RGN_HWREG 5'h0b
`define MMU_RGN_DISP 5'h0a
`define MMU_RGN_DRAM_TOP 5'h03

`endif

//--- rtl/mmu_pkg.sv
/*
  types of the user-segment translation block.
  assumes nothing beyond the params header.
*/
package mmu_pkg;

  typedef enum logic [7:0] {
    rgn_none = 8'h00,
    rgn_dram = 8'h01,
    rgn_disp = 8'h02,
    rgn_hwreg = 8'h04,
    rgn_mem8 = 8'h08,
    rgn_mem16 = 8'h10,
    rgn_io8 = 8'h20,
    rgn_io16 = 8'h40,
    rgn_rom = 8'h80
  } region_type;

  typedef logic [2:0] page_size_type;

endpackage

//--- test/mmu_user_map_chk.sv
/*
  concurrent checks on the pipeline side of the translation block.
  assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/1ns

module mmu_user_map_chk #(
  parameter int ENTRIES = 32,
  parameter int TAG_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic lookup_req,
  input wire logic [63:0] lookup_vaddr,
  input wire logic [31:0] lookup_paddr,
  input wire logic lookup_hit,
  input wire logic translation_miss,
  input wire logic extended_translation_miss,
  input wire logic address_error,
  input wire logic unmapped,
  input wire logic user_mode,
  input wire logic kernel_mode,
  input wire mmu_pkg::region_type region,
  input wire logic translation_shutdown_bit
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  logic valid_pa;
  logic fault;
  logic [4:0] code;
  assign valid_pa = lookup_hit | unmapped;
  assign fault = translation_miss | extended_translation_miss | address_error;
  assign code = lookup_paddr[28:24];
  ////////////////////////////////////////
  property p_quiet;
    !lookup_req |-> !valid_pa && !fault && lookup_paddr == 32'h0;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without lookup");
  property p_rom;
    valid_pa && code == 5'h1f |-> region == mmu_pkg::rgn_rom;
  endproperty
  a_rom: assert property (p_rom) else $error("rom decode wrong");
  property p_rom_alias;
    valid_pa && code == 5'h18 |-> region == mmu_pkg::rgn_rom;
  endproperty
  a_rom_alias: assert property (p_rom_alias) else $error("rom alias wrong");
  property p_io;
    valid_pa && code[4:1] == 4'hb |->
      region == (code[0] ? mmu_pkg::rgn_io16 : mmu_pkg::rgn_io8);
  endproperty
  a_io: assert property (p_io) else $error("io decode wrong");
  property p_mem;
    valid_pa && code[4:1] == 4'ha |->
      region == (code[0] ? mmu_pkg::rgn_mem16 : mmu_pkg::rgn_mem8);
  endproperty
  a_mem: assert property (p_mem) else $error("mem decode wrong");
  property p_regs;
    valid_pa && code[4:1] == 4'h5 |->
      region == (code[0] ? mmu_pkg::rgn_hwreg : mmu_pkg::rgn_disp);
  endproperty
  a_regs: assert property (p_regs) else $error("reg/disp decode wrong");
  property p_dram;
    valid_pa && code[4:2] == 3'h0 |-> region == mmu_pkg::rgn_dram;
  endproperty
  a_dram: assert property (p_dram) else $error("dram decode wrong");
  property p_offset;
    lookup_hit |-> lookup_paddr[9:0] == lookup_vaddr[9:0];
  endproperty
  a_offset: assert property (p_offset) else $error("offset altered");
  property p_fault_kernel;
    fault ##1 lookup_req |-> kernel_mode && !user_mode;
  endproperty
  a_fault_kernel: assert property (p_fault_kernel) else $error("no kernel");
  property p_sticky;
    translation_shutdown_bit |=> translation_shutdown_bit;
  endproperty
  a_sticky: assert property (p_sticky) else $error("shutdown lost");
  property p_err_alone;
    address_error |-> !lookup_hit && !translation_miss;
  endproperty
  a_err_alone: assert property (p_err_alone) else $error("error translated");
  c_hit: cover property (lookup_hit);
  c_xmiss: cover property (extended_translation_miss);
  c_shut: cover property ($rose(translation_shutdown_bit));
endmodule // mmu_user_map_chk

//--- test/pipe_model.sv
/*
  pipeline model issuing lookups and exception events.
  assumes the bench calls its tasks and samples results itself.
*/
`timescale 1ns/1ns

module pipe_model (
  input wire logic ref_clk,
  output logic lookup_req,
  output logic [63:0] lookup_vaddr,
  output logic exception_in,
  output logic exception_return
);
  initial begin
    lookup_req = 1'b0;
    lookup_vaddr = 64'h0;
    exception_in = 1'b0;
    exception_return = 1'b0;
  end
  task issue(input logic [63:0] va);
    @(posedge ref_clk);
    lookup_req <= 1'b1;
    lookup_vaddr <= va;
  endtask
  // a released address toggles so a stale value is never trusted
  task release_bus;
    @(posedge ref_clk);
    lookup_req <= 1'b0;
    lookup_vaddr <= ~lookup_vaddr;
  endtask
  task pulse(input logic ret);
    @(posedge ref_clk);
    exception_in <= !ret;
    exception_return <= ret;
    @(posedge ref_clk);
    exception_in <= 1'b0;
    exception_return <= 1'b0;
  endtask
endmodule // pipe_model

//--- test/mmu_translation_user_map_tb_top.sv
/*
  self-checking bench: registers over wishbone, lookups via pipe model.
  assumes the checker and the pipeline model are compiled first.
*/
`timescale 1ns/1ns
`include "mmu_params.svh"

`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end

module mmu_translation_user_map_tb_top;
  logic ref_clk = 1'b0, reset_n = 1'b0;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, lookup_paddr, rdat;
  logic ack_o, lookup_req, exception_in, exception_return, lookup_hit;
  logic lookup_cacheable, translation_miss, extended_translation_miss;
  logic address_error, unmapped, user_mode, kernel_mode;
  logic translation_shutdown_bit;
  logic [63:0] lookup_vaddr;
  mmu_pkg::region_type region;
  int err_count = 0, checks_done = 0;
  logic [31:0] pat [13] = '{32'h03ff_fc00, 32'h09ff_fc00, 32'h0aff_fc00,
    32'h0bff_fc00, 32'h1400_0000, 32'h1500_0000, 32'h1600_0000,
    32'h17ff_fc00, 32'h1800_0000, 32'h1900_0000, 32'h1eff_fc00,
    32'h3f00_0000, 32'hea00_0000};
  logic [7:0] rgt [13] = '{8'h01, 8'h00, 8'h02, 8'h04, 8'h08, 8'h10,
    8'h20, 8'h40, 8'h80, 8'h00, 8'h00, 8'h80, 8'h02};

  always #25 ref_clk = ~ref_clk;

  mmu_translation_user_map dut (.*);
  pipe_model pipe (.*);
  ////////////////////////////////////////
  task final_report;
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // a lookup still held would race a mode write, so drop it first
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    if (lookup_req === 1'b1) pipe.release_bus;
    @(posedge ref_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    repeat (16) begin
      @(posedge ref_clk);
      if (ack_o === 1'b1) break;
    end
    if (ack_o !== 1'b1) err_count++;
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hf);
    `CHK(rdat, e)
  endtask
  task load_entry(input logic [4:0] i, input logic [28:0] vpn,
      input logic [7:0] tg, input logic [31:0] lo0, lo1, input logic [2:0] k);
    wr(`MMU_VPN_OFS, {3'h0, vpn});
    wr(`MMU_TAG_OFS, {24'h0, tg});
    wr(`MMU_LO0_OFS, lo0);
    wr(`MMU_LO1_OFS, lo1);
    wr(`MMU_SIZE_OFS, {29'h0, k});
    wr(`MMU_INDEX_OFS, {27'h0, i});
    wr(`MMU_CMD_OFS, 32'h1);
  endtask
  task look(input logic [63:0] va, input logic [5:0] f,
      input logic [31:0] pa, input logic [7:0] r);
    pipe.issue(va);
    @(negedge ref_clk);
    `CHK({user_mode, lookup_hit, lookup_cacheable, translation_miss,
      extended_translation_miss, address_error}, f)
    `CHK(lookup_paddr, pa)
    `CHK(region, r)
  endtask
  task kchk;
    @(negedge ref_clk);
    `CHK({kernel_mode, user_mode}, 2'h2)
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`MMU_MODE_OFS, 32'h4);
    rd(`MMU_STATUS_OFS, 32'h0);
    rd(8'h3c, 32'h0);
    load_entry(5'h0, 29'h8, 8'h05, 32'h0042_8000, 32'h0007_c000, 3'h0);
    wb(1'b1, `MMU_TAG_OFS, 32'hffff_ff05, 4'h1);
    rd(`MMU_TAG_OFS, 32'h5);
    wr(`MMU_MODE_OFS, 32'h10);
    look(64'hdead_beef_0000_4123, 6'h38, 32'h0a00_0123, 8'h02);
    look(64'h4523, 6'h30, 32'h1f00_0123, 8'h80);
    wr(`MMU_TAG_OFS, 32'h6);
    look(64'h4123, 6'h24, 32'h0, 8'h00);
    kchk;
    wr(`MMU_MODE_OFS, 32'h10);
    look(64'h8000_4123, 6'h21, 32'h0, 8'h00);
    kchk;
    look(64'h8000_4123, 6'h00, 32'h8000_4123, 8'h01);
    `CHK(unmapped, 1'b1)
    wr(`MMU_MODE_OFS, 32'h30);
    look(64'h0100_0000_4123, 6'h21, 32'h0, 8'h00);
    wr(`MMU_MODE_OFS, 32'h30);
    look(64'h0080_0000_4123, 6'h22, 32'h0, 8'h00);
    load_entry(5'h1, 29'h1fe0_1000, 8'h77, 32'h00c0_0000, 32'h0082_c000,
      3'h4);
    wr(`MMU_TAG_OFS, 32'h6);
    wr(`MMU_MODE_OFS, 32'h30);
    look(64'hff_0083_2345, 6'h38, 32'h0003_2345, 8'h01);
    look(64'hff_0087_2345, 6'h30, 32'h0b03_2345, 8'h04);
    wr(`MMU_MODE_OFS, 32'h10);
    for (int i = 0; i < 13; i++) begin
      load_entry(5'h0, 29'h8, 8'h05, {10'h0, pat[i][31:10]}, 32'h0, 3'h0);
      look(64'h4000, 6'h30, pat[i], rgt[i]);
    end
    pipe.release_bus;
    pipe.pulse(1'b0);
    rd(`MMU_MODE_OFS, 32'h12);
    pipe.pulse(1'b1);
    rd(`MMU_MODE_OFS, 32'h10);
    load_entry(5'h2, 29'h8, 8'h05, 32'h0, 32'h0, 3'h0);
    wr(`MMU_MODE_OFS, 32'h10);
    pipe.issue(64'h4000);
    repeat (2) @(negedge ref_clk);
    `CHK(translation_shutdown_bit, 1'b1)
    wr(`MMU_MODE_OFS, 32'h10);
    look(64'h4123, 6'h24, 32'h0, 8'h00);
    rd(`MMU_STATUS_OFS, 32'h3);
    pipe.release_bus;
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    `CHK(translation_shutdown_bit, 1'b0)
    rd(`MMU_MODE_OFS, 32'h4);
    final_report;
  end
  initial begin
    #150000;
    err_count++;
    final_report;
  end
endmodule // mmu_translation_user_map_tb_top

bind mmu_translation_user_map mmu_user_map_chk #(.ENTRIES(ENTRIES),
  .TAG_W(TAG_W)) u_chk (.*);
